// File: rtl/modem_pins_pkg.sv
// modem-pin and flow-control constants, register map and field layouts
// assumes a 32-bit apb slave with 8-bit byte addresses, one register per word
package modem_pins_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] REG_ADDITIONAL_CTRL = 8'h00;
    localparam logic [7:0] REG_CLOCK_SELECT = 8'h04;
    localparam logic [7:0] REG_FLOW = 8'h08;
    localparam logic [7:0] REG_THRESHOLD = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // additional_control_field: bits 4:3 steer the terminal-ready pin
    localparam int unsigned ACF_DTR_LO = 3;
    localparam logic [1:0] DTR_MANUAL = 2'h0;
    localparam logic [1:0] DTR_AUTO_FLOW = 2'h1;
    localparam logic [1:0] DTR_485_LOW = 2'h2;
    localparam logic [1:0] DTR_485_HIGH = 2'h3;

    // clock_select_field layout
    localparam int unsigned CSF_RX_LO = 0;
    localparam logic [1:0] CSF_RX_FROM_DSR = 2'h1;
    localparam int unsigned CSF_DTR_LO = 4;
    localparam logic [1:0] CSF_DTR_1X = 2'h1;
    localparam logic [1:0] CSF_DTR_NX = 2'h2;
    localparam int unsigned CSF_TX_FROM_RI = 6;

    // reset values
    localparam logic [7:0] ACF_RESET = 8'h00;
    localparam logic [7:0] CSF_RESET = 8'h00;
    localparam logic [7:0] UPPER_RESET = 8'h60;
    localparam logic [7:0] LOWER_RESET = 8'h20;

    // strap capture: cycles the synchronised straps are sampled after reset
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    typedef struct packed {
        logic out2_on;
        logic general_output_one_n_on;
        logic dtr_on;
        logic rts_on;
        logic auto_dsr;
        logic auto_cts;
        logic auto_rts;
    } flow_ctrl_t;

    localparam flow_ctrl_t FLOW_RESET = 7'h00;

    typedef struct packed {
        logic [7:0] lower;
        logic [7:0] upper;
    } threshold_t;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_LOCAL_BUS,
        MODE_EMBEDDED
    } op_mode_t;

endpackage

// File: rtl/pin_sync2.sv
// two-flop synchroniser for a bundle of independent pin levels
// assumes each bit is a slow level; no bus coherence across bits is offered
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end

endmodule

`default_nettype wire

// File: rtl/uart_modem_pins_flow_ctrl.sv
// modem-control pins, hardware flow control and shared local-bus pins of a uart
// assumes fifo level, transmitter status and baud clocks arrive on pclk
`timescale 1ns/1ps
`default_nettype none

module uart_modem_pins_flow_ctrl (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receiver fifo and transmitter
    input wire logic [7:0] rx_fill_level,
    input wire logic tx_empty,
    input wire logic tx_start_req,
    input wire logic tx_flow_char,
    output logic tx_start_allow,
    input wire logic tx_clk_1x,
    input wire logic tx_clk_nx,
    // external clock selection
    output logic rx_ext_clk_sel,
    output logic tx_ext_clk_sel,
    output logic rx_ext_clk_rise,
    output logic tx_ext_clk_rise,
    // modem pins
    input wire logic cts_n_pin,
    input wire logic dsr_n_pin,
    input wire logic ri_n_pin,
    output logic rts_n_pin,
    output logic dtr_n_pin,
    // straps
    input wire logic mode_pin,
    input wire logic eeprom_serial_in,
    output logic local_bus_mode,
    output logic embedded_local_mode,
    // local-bus and embedded sources
    input wire logic lb_select_n_int,
    input wire logic lb_read_n_int,
    input wire logic lb_write_n_int,
    input wire logic lb_reset_int,
    input wire logic rx_ready_n_int,
    input wire logic tx_ready_n_int,
    // shared pins, index 0..3 = address bits 4..7
    input wire logic [3:0] shared_in,
    output logic [3:0] shared_out,
    output logic [3:0] shared_oe,
    output logic [3:0] addr_hi
);

    // synchronised pin levels
    logic [8:0] pins_raw;
    logic [8:0] pins_s;
    logic cts_n_s;
    logic dsr_n_s;
    logic ri_n_s;
    logic mode_s;
    logic ee_s;

    assign pins_raw = {shared_in, eeprom_serial_in, mode_pin, ri_n_pin, dsr_n_pin, cts_n_pin};

    pin_sync2 #(.W(9)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(pins_raw),
        .dout(pins_s)
    );

    assign cts_n_s = pins_s[0];
    assign dsr_n_s = pins_s[1];
    assign ri_n_s = pins_s[2];
    assign mode_s = pins_s[3];
    assign ee_s = pins_s[4];
    assign addr_hi = pins_s[8:5];

    // registers
    logic [7:0] acf_q;
    logic [7:0] csf_q;
    modem_pins_pkg::flow_ctrl_t flow_q;
    modem_pins_pkg::threshold_t thr_q;
    logic [31:0] prdata_q;
    logic slverr_q;

    // apb decode
    wire setup_ph = psel & ~penable;
    wire access_ph = psel & penable;
    wire sel_acf = (paddr == modem_pins_pkg::REG_ADDITIONAL_CTRL);
    wire sel_csf = (paddr == modem_pins_pkg::REG_CLOCK_SELECT);
    wire sel_flow = (paddr == modem_pins_pkg::REG_FLOW);
    wire sel_thr = (paddr == modem_pins_pkg::REG_THRESHOLD);
    wire sel_stat = (paddr == modem_pins_pkg::REG_STATUS);
    wire mapped = sel_acf | sel_csf | sel_flow | sel_thr | sel_stat;
    wire wr_en = access_ph & pwrite & mapped;

    // field views
    wire [1:0] dtr_mode = acf_q[modem_pins_pkg::ACF_DTR_LO +: 2];
    wire [1:0] csf_rx = csf_q[modem_pins_pkg::CSF_RX_LO +: 2];
    wire [1:0] csf_dtr = csf_q[modem_pins_pkg::CSF_DTR_LO +: 2];

    // strap capture and mode
    logic [1:0] strap_cnt_q;
    modem_pins_pkg::op_mode_t mode_q;
    modem_pins_pkg::op_mode_t mode_d;

    // flow-control state
    logic rts_hold_q;
    logic rts_hold_d;
    logic dtr_hold_q;
    logic dtr_hold_d;
    logic rts_n_q;
    logic dtr_n_q;
    logic dtr_n_d;
    logic dsr_prev_q;
    logic ri_prev_q;
    logic [3:0] sh_out_q;
    logic [3:0] sh_oe_q;
    logic [3:0] sh_out_d;
    logic [3:0] sh_oe_d;

    // hysteresis: set at the upper mark, released once the level falls below the lower one
    wire at_upper = (rx_fill_level >= thr_q.upper);
    assign rts_hold_d = at_upper ? 1'b1 : ((rx_fill_level < thr_q.lower) ? 1'b0 : rts_hold_q);
    assign dtr_hold_d = at_upper ? 1'b1 : ((rx_fill_level < thr_q.lower) ? 1'b0 : dtr_hold_q);

    wire rts_n_d = flow_q.auto_rts ? rts_hold_d : ~flow_q.rts_on;

    // clock output wins over the other terminal-ready uses
    always_comb begin
        if (csf_dtr == modem_pins_pkg::CSF_DTR_1X) begin
            dtr_n_d = tx_clk_1x;
        end else if (csf_dtr == modem_pins_pkg::CSF_DTR_NX) begin
            dtr_n_d = tx_clk_nx;
        end else begin
            case (dtr_mode)
                modem_pins_pkg::DTR_AUTO_FLOW: dtr_n_d = dtr_hold_d;
                modem_pins_pkg::DTR_485_LOW: dtr_n_d = tx_empty;
                modem_pins_pkg::DTR_485_HIGH: dtr_n_d = ~tx_empty;
                default: dtr_n_d = ~flow_q.dtr_on;
            endcase
        end
    end

    // gating acts only on a new start, so a character on the line always completes
    wire tx_hold = (flow_q.auto_cts & cts_n_s) | (flow_q.auto_dsr & dsr_n_s);
    assign tx_start_allow = tx_start_req & (tx_flow_char | ~tx_hold);

    // external clocks, edges taken from the synchronised levels only
    assign rx_ext_clk_sel = (csf_rx == modem_pins_pkg::CSF_RX_FROM_DSR);
    assign tx_ext_clk_sel = csf_q[modem_pins_pkg::CSF_TX_FROM_RI];
    assign rx_ext_clk_rise = rx_ext_clk_sel & dsr_n_s & ~dsr_prev_q;
    assign tx_ext_clk_rise = tx_ext_clk_sel & ri_n_s & ~ri_prev_q;

    // straps are sampled a few cycles after release, then frozen
    always_comb begin
        if (!mode_s) begin
            mode_d = modem_pins_pkg::MODE_NORMAL;
        end else if (!ee_s) begin
            mode_d = modem_pins_pkg::MODE_EMBEDDED;
        end else begin
            mode_d = modem_pins_pkg::MODE_LOCAL_BUS;
        end
    end

    // shared pin drive per mode
    always_comb begin
        case (mode_q)
            modem_pins_pkg::MODE_LOCAL_BUS: begin
                sh_out_d = {lb_write_n_int, lb_read_n_int, lb_select_n_int, lb_reset_int};
                sh_oe_d = 4'hF;
            end
            modem_pins_pkg::MODE_EMBEDDED: begin
                sh_out_d = {tx_ready_n_int, rx_ready_n_int, ~flow_q.general_output_one_n_on, ~flow_q.out2_on};
                sh_oe_d = 4'hF;
            end
            default: begin
                sh_out_d = 4'h0;
                sh_oe_d = 4'h0;
            end
        endcase
    end

    wire [31:0] status_word = {22'h000000, mode_q == modem_pins_pkg::MODE_EMBEDDED,
        mode_q == modem_pins_pkg::MODE_LOCAL_BUS, tx_hold, dtr_n_q, rts_n_q, dtr_hold_q, rts_hold_q,
        ri_n_s, dsr_n_s, cts_n_s};

    wire [31:0] rd_mux = sel_acf ? {24'h000000, acf_q} :
        sel_csf ? {24'h000000, csf_q} :
        sel_flow ? {25'h0000000, flow_q} :
        sel_thr ? {16'h0000, thr_q} :
        sel_stat ? status_word : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acf_q <= modem_pins_pkg::ACF_RESET;
            csf_q <= modem_pins_pkg::CSF_RESET;
            flow_q <= modem_pins_pkg::FLOW_RESET;
            thr_q <= {modem_pins_pkg::LOWER_RESET, modem_pins_pkg::UPPER_RESET};
        end else if (wr_en) begin
            if (sel_acf) acf_q <= pwdata[7:0];
            if (sel_csf) csf_q <= pwdata[7:0];
            if (sel_flow) flow_q <= pwdata[6:0];
            if (sel_thr) thr_q <= pwdata[15:0];
        end
    end

    // read data is loaded in the setup cycle so a zero-wait access sees it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
            slverr_q <= 1'b0;
        end else if (setup_ph) begin
            prdata_q <= pwrite ? 32'h00000000 : rd_mux;
            slverr_q <= ~mapped;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = access_ph & slverr_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_cnt_q <= 2'h0;
            mode_q <= modem_pins_pkg::MODE_NORMAL;
        end else if (strap_cnt_q != modem_pins_pkg::STRAP_SETTLE) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rts_hold_q <= 1'b0;
            dtr_hold_q <= 1'b0;
            rts_n_q <= 1'b1;
            dtr_n_q <= 1'b1;
            dsr_prev_q <= 1'b0;
            ri_prev_q <= 1'b0;
            sh_out_q <= 4'h0;
            sh_oe_q <= 4'h0;
        end else begin
            rts_hold_q <= rts_hold_d;
            dtr_hold_q <= dtr_hold_d;
            rts_n_q <= rts_n_d;
            dtr_n_q <= dtr_n_d;
            dsr_prev_q <= dsr_n_s;
            ri_prev_q <= ri_n_s;
            sh_out_q <= sh_out_d;
            sh_oe_q <= sh_oe_d;
        end
    end

    assign rts_n_pin = rts_n_q;
    assign dtr_n_pin = dtr_n_q;
    assign shared_out = sh_out_q;
    assign shared_oe = sh_oe_q;
    assign local_bus_mode = (mode_q == modem_pins_pkg::MODE_LOCAL_BUS);
    assign embedded_local_mode = (mode_q == modem_pins_pkg::MODE_EMBEDDED);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_rts_upper_mark: assert property (flow_q.auto_rts && at_upper |=> rts_n_pin)
        else $error("rts not deasserted at upper mark");
    chk_rts_lower_mark: assert property (flow_q.auto_rts && rx_fill_level < thr_q.lower && !at_upper
        |=> !rts_n_pin)
        else $error("rts not reasserted below lower mark");
    chk_dtr_auto_flow: assert property (dtr_mode == modem_pins_pkg::DTR_AUTO_FLOW && csf_dtr == 2'h0
        && at_upper |=> dtr_n_pin)
        else $error("dtr not deasserted at upper mark");
    chk_dtr_rs485_dir: assert property (dtr_mode == modem_pins_pkg::DTR_485_LOW && csf_dtr == 2'h0
        |=> dtr_n_pin == $past(tx_empty))
        else $error("dtr does not follow tx empty");
    chk_dtr_clock_out: assert property (csf_dtr == modem_pins_pkg::CSF_DTR_1X
        |=> dtr_n_pin == $past(tx_clk_1x))
        else $error("dtr does not carry 1x clock");
    chk_cts_tx_gate: assert property (flow_q.auto_cts && cts_n_s && !tx_flow_char |-> !tx_start_allow)
        else $error("start allowed while cts deasserted");
    chk_dsr_tx_gate: assert property (flow_q.auto_dsr && dsr_n_s && !tx_flow_char |-> !tx_start_allow)
        else $error("start allowed while dsr deasserted");
    chk_flow_char_pass: assert property (tx_start_req && tx_flow_char |-> tx_start_allow)
        else $error("flow character blocked");
    chk_rx_ext_edge: assert property (csf_rx == modem_pins_pkg::CSF_RX_FROM_DSR && $rose(dsr_n_s)
        |-> rx_ext_clk_rise)
        else $error("rx external clock edge missed");
    chk_tx_ext_edge: assert property (csf_q[modem_pins_pkg::CSF_TX_FROM_RI] && $rose(ri_n_s)
        |-> tx_ext_clk_rise)
        else $error("tx external clock edge missed");
    chk_local_bus_pins: assert property (local_bus_mode && $stable(mode_q) |=> shared_oe == 4'hF
        && shared_out == {$past(lb_write_n_int), $past(lb_read_n_int), $past(lb_select_n_int),
        $past(lb_reset_int)})
        else $error("local bus pins not driven");
    chk_normal_pins_idle: assert property (mode_q == modem_pins_pkg::MODE_NORMAL ##1
        mode_q == modem_pins_pkg::MODE_NORMAL |-> shared_oe == 4'h0)
        else $error("shared pins driven in normal mode");

    cov_rts_throttle: cover property (flow_q.auto_rts && !rts_n_pin ##1 rts_n_pin);
    cov_cts_gated: cover property (tx_start_req && !tx_start_allow);
    cov_embedded: cover property (embedded_local_mode && shared_oe == 4'hF);
    cov_ext_clk: cover property (rx_ext_clk_rise);

endmodule

`default_nettype wire

// File: verif/line_partner.sv
// far-side modem model: drives the three modem inputs of the block
// assumes the bench steers it through plain level controls on pclk
`timescale 1ns/1ps
`default_nettype none

module line_partner (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // scenario controls
    input wire logic cts_off,
    input wire logic dsr_off,
    input wire logic dsr_clk_run,
    input wire logic ri_clk_run,
    // modem pins
    output logic cts_n_pin,
    output logic dsr_n_pin,
    output logic ri_n_pin
);
    logic [1:0] div_q;
    logic clk_q;

    // external clock stands still outside bursts so stray edges cannot hide
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 2'h0;
            clk_q <= 1'b0;
        end else if (dsr_clk_run || ri_clk_run) begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3) clk_q <= ~clk_q;
        end else begin
            div_q <= 2'h0;
            clk_q <= 1'b0;
        end
    end

    assign cts_n_pin = cts_off;
    assign dsr_n_pin = dsr_clk_run ? clk_q : dsr_off;
    assign ri_n_pin = ri_clk_run ? clk_q : 1'b1;
endmodule

`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the modem pins block with an apb master
// assumes the line_partner model and the design package are compiled first
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end

module testbench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, rx_fill_level = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, tx_start_allow, rx_sel, tx_sel, rx_rise, tx_rise, rts_n_pin, dtr_n_pin;
    logic tx_empty = 0, tx_start_req = 0, tx_flow_char = 0, tx_clk_1x = 0, tx_clk_nx = 0;
    logic cts_n_pin, dsr_n_pin, ri_n_pin, cts_off = 0, dsr_off = 0, dsr_clk_run = 0, ri_clk_run = 0;
    logic mode_pin = 0, ee_in = 1, lb_mode, emb_mode;
    logic lb_sel_n = 1, lb_rd_n = 1, lb_wr_n = 1, lb_rst = 0, rx_rdy_n = 1, tx_rdy_n = 1;
    logic [3:0] shared_in = 4'h0, shared_out, shared_oe, addr_hi;
    int fail_count = 0, total_checks = 0;

    always #25 pclk = ~pclk;

    uart_modem_pins_flow_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_fill_level(rx_fill_level), .tx_empty(tx_empty),
        .tx_start_req(tx_start_req), .tx_flow_char(tx_flow_char), .tx_start_allow(tx_start_allow),
        .tx_clk_1x(tx_clk_1x), .tx_clk_nx(tx_clk_nx), .rx_ext_clk_sel(rx_sel), .tx_ext_clk_sel(tx_sel),
        .rx_ext_clk_rise(rx_rise), .tx_ext_clk_rise(tx_rise), .cts_n_pin(cts_n_pin),
        .dsr_n_pin(dsr_n_pin), .ri_n_pin(ri_n_pin), .rts_n_pin(rts_n_pin), .dtr_n_pin(dtr_n_pin),
        .mode_pin(mode_pin), .eeprom_serial_in(ee_in), .local_bus_mode(lb_mode),
        .embedded_local_mode(emb_mode), .lb_select_n_int(lb_sel_n), .lb_read_n_int(lb_rd_n),
        .lb_write_n_int(lb_wr_n), .lb_reset_int(lb_rst), .rx_ready_n_int(rx_rdy_n),
        .tx_ready_n_int(tx_rdy_n), .shared_in(shared_in), .shared_out(shared_out),
        .shared_oe(shared_oe), .addr_hi(addr_hi));

    line_partner far_end (.pclk(pclk), .presetn(presetn), .cts_off(cts_off), .dsr_off(dsr_off),
        .dsr_clk_run(dsr_clk_run), .ri_clk_run(ri_clk_run), .cts_n_pin(cts_n_pin),
        .dsr_n_pin(dsr_n_pin), .ri_n_pin(ri_n_pin));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin fail_count++; end_of_test(); end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
        repeat (4) @(posedge pclk);
    endtask

    task automatic do_reset(input logic m, input logic ee);
        presetn <= 1'b0; mode_pin <= m; ee_in <= ee;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask

    task automatic t_regs();
        logic [31:0] rd;
        logic er;
        logic [7:0] a[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
        logic [31:0] e[6] = '{32'h0, 32'h0, 32'h0, 32'h2060, 32'h64, 32'h0};
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, a[i], 32'h0, rd, er);
            `CHK("reg_value", e[i], rd)
            `CHK("reg_error", (i == 5), er)
        end
        apb(1'b1, 8'h14, 32'hFF, rd, er);
        `CHK("unmapped_wr_err", 1'b1, er)
        apb(1'b1, modem_pins_pkg::REG_STATUS, 32'hFFFF, rd, er);
        `CHK("ro_wr_err", 1'b0, er)
        $display("test regs done");
    endtask

    task automatic t_rts();
        logic [7:0] f[4] = '{8'h0F, 8'h10, 8'h08, 8'h07};
        logic e[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        wr(modem_pins_pkg::REG_THRESHOLD, 32'h0810);
        wr(modem_pins_pkg::REG_FLOW, 32'h09);
        for (int i = 0; i < 4; i++) begin
            rx_fill_level <= f[i];
            repeat (3) @(posedge pclk);
            `CHK("rts_n_pin", e[i], rts_n_pin)
        end
        $display("test rts done");
    endtask

    task automatic t_dtr();
        logic [7:0] f[4] = '{8'h0F, 8'h10, 8'h08, 8'h07};
        logic e[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        wr(modem_pins_pkg::REG_FLOW, 32'h10);
        wr(modem_pins_pkg::REG_ADDITIONAL_CTRL, 32'h08);
        for (int i = 0; i < 4; i++) begin
            rx_fill_level <= f[i];
            repeat (3) @(posedge pclk);
            `CHK("dtr_n_auto", e[i], dtr_n_pin)
        end
        $display("test dtr done");
    endtask

    task automatic t_485();
        for (int v = 2; v < 4; v++) begin
            wr(modem_pins_pkg::REG_ADDITIONAL_CTRL, 32'(v) << 3);
            for (int t = 0; t < 2; t++) begin
                tx_empty <= t[0];
                repeat (3) @(posedge pclk);
                `CHK("dtr_n_485", t[0] ^ (v == 3), dtr_n_pin)
            end
        end
        wr(modem_pins_pkg::REG_ADDITIONAL_CTRL, 32'h0);
        `CHK("dtr_n_manual", 1'b0, dtr_n_pin)
        $display("test rs485 done");
    endtask

    task automatic t_gate();
        logic [2:0] s[5] = '{3'h4, 3'h5, 3'h2, 3'h3, 3'h0};
        logic e[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        wr(modem_pins_pkg::REG_FLOW, 32'h06);
        tx_start_req <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            {cts_off, dsr_off, tx_flow_char} <= s[i];
            repeat (4) @(posedge pclk);
            `CHK("tx_start_allow", e[i], tx_start_allow)
        end
        tx_start_req <= 1'b0;
        $display("test gating done");
    endtask

    task automatic count_edges(input logic use_ri, output int pin_r, output int dut_r);
        logic prev, now;
        pin_r = 0;
        dut_r = 0;
        prev = use_ri ? ri_n_pin : dsr_n_pin;
        if (use_ri) ri_clk_run <= 1'b1;
        else dsr_clk_run <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge pclk);
            if (i == 31) begin ri_clk_run <= 1'b0; dsr_clk_run <= 1'b0; end
            now = use_ri ? ri_n_pin : dsr_n_pin;
            if (now && !prev && i < 33) pin_r++;
            prev = now;
            if ((use_ri ? tx_rise : rx_rise) === 1'b1) dut_r++;
        end
    endtask

    task automatic t_extclk();
        int pin_r, dut_r;
        wr(modem_pins_pkg::REG_CLOCK_SELECT, 32'h01);
        `CHK("ext_sel_rx", 2'h2, {rx_sel, tx_sel})
        count_edges(1'b0, pin_r, dut_r);
        `CHK("rx_ext_rises", pin_r, dut_r)
        wr(modem_pins_pkg::REG_CLOCK_SELECT, 32'h40);
        `CHK("ext_sel_tx", 2'h1, {rx_sel, tx_sel})
        count_edges(1'b1, pin_r, dut_r);
        `CHK("tx_ext_rises", pin_r, dut_r)
        for (int s = 1; s < 3; s++) begin
            wr(modem_pins_pkg::REG_CLOCK_SELECT, 32'(s) << 4);
            for (int i = 0; i < 4; i++) begin
                tx_clk_1x <= i[0];
                tx_clk_nx <= ~i[0];
                repeat (3) @(posedge pclk);
                `CHK("dtr_clk_out", i[0] ^ (s == 2), dtr_n_pin)
            end
        end
        wr(modem_pins_pkg::REG_CLOCK_SELECT, 32'h0);
        $display("test clocks done");
    endtask

    task automatic t_modes();
        do_reset(1'b0, 1'b1);
        shared_in <= 4'hA;
        repeat (4) @(posedge pclk);
        `CHK("normal_mode", 3'h0, {lb_mode, emb_mode, |shared_oe})
        `CHK("addr_hi", 4'hA, addr_hi)
        do_reset(1'b1, 1'b1);
        for (int p = 5; p < 11; p += 5) begin
            {lb_wr_n, lb_rd_n, lb_sel_n, lb_rst} <= 4'(p);
            repeat (4) @(posedge pclk);
            `CHK("lb_mode", 2'h2, {lb_mode, emb_mode})
            `CHK("lb_oe", 4'hF, shared_oe)
            `CHK("lb_out", 4'(p), shared_out)
        end
        do_reset(1'b1, 1'b0);
        {tx_rdy_n, rx_rdy_n} <= 2'h1;
        wr(modem_pins_pkg::REG_FLOW, 32'h20);
        `CHK("emb_mode", 2'h1, {lb_mode, emb_mode})
        `CHK("emb_oe", 4'hF, shared_oe)
        `CHK("emb_out", 4'h5, shared_out)
        $display("test modes done");
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        end_of_test();
    end

    initial begin
        do_reset(1'b0, 1'b1);
        t_regs();
        t_rts();
        t_dtr();
        t_485();
        t_gate();
        t_extclk();
        t_modes();
        end_of_test();
    end
endmodule

`default_nettype wire
